//--- rsic_ctrl.sv
// Purpose: reset sequencing, vector fetch, standby and vectored interrupt control
// Assumes: pclk 20 MHz, reset pin and irq pins asynchronous to pclk
// Notes: registers reached over apb; the cpu core sits on the other side
// Function
// - low reset pin holds system reset
// - rising reset releases, then vector fetch
// - pc high from byte 000, low 001
// - interrupt vectors stored from byte 002
// - accept pushes pc and psw, loads vector
// - test edge sets flag, never vectors
// - no new acceptance while servicing
// - accept needs source and global enable
// - software reads every request flag
// - halt wakes on enabled non-external request
// - stop halts clock, timer, clock output, cpu
// - serial runs in stop only with external clock
// - halt stops only cpu clock, timer runs
// - test input usable, external irq not, in standby
// - standby ends on reset or enabled request
// - reset clears control, mode, flag registers
// - standby reset retains carry, ram, serial data
// - standby reset marks ram 38..3D undefined
// - outputs off during and after reset
`default_nettype none
module rsic_ctrl #(
  parameter int TIMER_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic ext_vectored_irq_in,
  input wire logic ext_test_edge_in,
  input wire logic timer_tick,
  input wire logic serial_done,
  input wire logic [7:0] prog_rdata,
  output logic [10:0] prog_addr,
  output logic prog_rd,
  output logic [10:0] pc_load_value,
  output logic pc_load,
  output logic ctx_push,
  output logic sys_reset,
  output logic cpu_clk_en,
  output logic osc_en,
  output logic timer_run,
  output logic clk_out_en,
  output logic serial_run,
  output logic ext_irq_usable,
  output logic out_buf_en,
  output logic retain_ok,
  output logic ram_lost_valid,
  output logic [5:0] ram_lost_lo,
  output logic [5:0] ram_lost_hi,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic vi_s1;
    logic vi_s2;
    logic vi_d;
    logic te_s1;
    logic te_s2;
    logic te_d;
    rsic_pkg::rsic_state_t st;
    logic in_standby;
    logic standby_reset;
    logic [2:0] vec_hi;
    logic [1:0] vec_idx;
    logic [2:0] irq_req;
    logic test_req;
    logic [2:0] irq_en;
    logic global_en;
    logic in_service;
    logic edge_mode;
    logic [3:0] cpu_clk_sel;
    logic [3:0] clk_out_sel;
    logic [3:0] timer_mode;
    logic [3:0] serial_mode;
    logic [3:0] serial_ctrl;
    logic [3:0] port_dir_a;
    logic [3:0] port_dir_b;
    logic [3:0] pullup_sel;
    logic [3:0] out_latch;
    logic [2:0] skip_flags;
    logic [31:0] rdata;
    logic rdata_seen;
  } rsic_regs_t;

  rsic_regs_t s_q;
  rsic_regs_t s_d;

  logic acc;
  logic wr;
  logic rd;
  logic addr_ok;
  logic [2:0] pend;
  logic [2:0] pick;
  logic wake;
  logic serial_ext_clk;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign addr_ok = (paddr <= rsic_pkg::OFS_RETAIN) && (paddr[1:0] == 2'h0);
  assign serial_ext_clk = s_q.serial_mode[3];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rst_s1 = reset_pin_n;
    s_d.rst_s2 = s_q.rst_s1;
    s_d.vi_s1 = ext_vectored_irq_in;
    s_d.vi_s2 = s_q.vi_s1;
    s_d.vi_d = s_q.vi_s2;
    s_d.te_s1 = ext_test_edge_in;
    s_d.te_s2 = s_q.te_s1;
    s_d.te_d = s_q.te_s2;
    s_d.rdata = rsic_pkg::ZERO32;
    // read data is registered, so the second access cycle carries the answer
    s_d.rdata_seen = rd && !s_q.rdata_seen;

    // software writes first so hardware sets below win
    if (wr && addr_ok) begin
      unique case (paddr)
        rsic_pkg::OFS_CTRL: begin
          s_d.global_en = pwdata[0];
          s_d.edge_mode = pwdata[1];
          s_d.skip_flags = pwdata[6:4];
        end
        rsic_pkg::OFS_IRQ_EN: s_d.irq_en = pwdata[2:0];
        // write one to clear request flags
        rsic_pkg::OFS_IRQ_REQ: begin
          s_d.irq_req = s_q.irq_req & ~pwdata[2:0];
          s_d.test_req = s_q.test_req & ~pwdata[3];
        end
        rsic_pkg::OFS_MODES: begin
          s_d.cpu_clk_sel = pwdata[3:0];
          s_d.clk_out_sel = pwdata[7:4];
          s_d.timer_mode = pwdata[11:8];
          s_d.serial_mode = pwdata[15:12];
          s_d.serial_ctrl = pwdata[19:16];
        end
        rsic_pkg::OFS_PORTCFG: begin
          s_d.port_dir_a = pwdata[3:0];
          s_d.port_dir_b = pwdata[7:4];
          s_d.pullup_sel = pwdata[11:8];
          s_d.out_latch = pwdata[15:12];
        end
        default: begin
        end
      endcase
    end

    if (rd) begin
      unique case (paddr)
        rsic_pkg::OFS_CTRL:
          s_d.rdata = {25'h0, s_q.skip_flags, 2'h0, s_q.edge_mode, s_q.global_en};
        rsic_pkg::OFS_IRQ_EN: s_d.rdata = {29'h0, s_q.irq_en};
        rsic_pkg::OFS_IRQ_REQ: s_d.rdata = {28'h0, s_q.test_req, s_q.irq_req};
        rsic_pkg::OFS_STATUS:
          s_d.rdata = {24'h0, s_q.standby_reset, s_q.in_standby, s_q.in_service,
                       2'h0, s_q.st};
        rsic_pkg::OFS_MODES:
          s_d.rdata = {12'h0, s_q.serial_ctrl, s_q.serial_mode, s_q.timer_mode,
                       s_q.clk_out_sel, s_q.cpu_clk_sel};
        rsic_pkg::OFS_PORTCFG:
          s_d.rdata = {16'h0, s_q.out_latch, s_q.pullup_sel, s_q.port_dir_b,
                       s_q.port_dir_a};
        rsic_pkg::OFS_RETAIN: s_d.rdata = {31'h0, s_q.standby_reset};
        default: s_d.rdata = rsic_pkg::ZERO32;
      endcase
    end

    unique case (s_q.st)
      // held while the synced pin is low
      rsic_pkg::ST_RESET: begin
        if (s_q.rst_s2) begin
          s_d.st = rsic_pkg::ST_FETCH_HI;
        end
      end
      rsic_pkg::ST_FETCH_HI: begin
        s_d.vec_hi = prog_rdata[2:0];
        s_d.st = rsic_pkg::ST_FETCH_LO;
      end
      rsic_pkg::ST_FETCH_LO: s_d.st = rsic_pkg::ST_RUN;
      rsic_pkg::ST_RUN: begin
        if (wr && paddr == rsic_pkg::OFS_CMD && pwdata[1:0] == rsic_pkg::CMD_HALT) begin
          s_d.st = rsic_pkg::ST_HALT;
          s_d.in_standby = 1'b1;
        end else if (wr && paddr == rsic_pkg::OFS_CMD
                     && pwdata[1:0] == rsic_pkg::CMD_STOP) begin
          s_d.st = rsic_pkg::ST_STOP;
          s_d.in_standby = 1'b1;
        end else if (|pick && !s_q.in_service) begin
          s_d.st = rsic_pkg::ST_VEC_PUSH;
          s_d.vec_idx = pick[0] ? 2'h0 : (pick[1] ? 2'h1 : 2'h2);
        end
        if (wr && paddr == rsic_pkg::OFS_CMD && pwdata[1:0] == rsic_pkg::CMD_RETI) begin
          s_d.in_service = 1'b0;
        end
      end
      // leave standby on enabled wake source
      rsic_pkg::ST_HALT, rsic_pkg::ST_STOP: begin
        if (wake) begin
          s_d.st = rsic_pkg::ST_RUN;
          s_d.in_standby = 1'b0;
        end
      end
      // push context and take vector high bits, then low byte
      rsic_pkg::ST_VEC_PUSH: begin
        s_d.vec_hi = prog_rdata[2:0];
        s_d.st = rsic_pkg::ST_VEC_LOAD;
      end
      rsic_pkg::ST_VEC_LOAD: begin
        s_d.irq_req[s_q.vec_idx] = 1'b0;
        s_d.in_service = 1'b1;
        s_d.st = rsic_pkg::ST_RUN;
      end
    endcase

    // hardware sets come after the write and vector-load clears so a new event is not lost; the pin reset below still clears them
    // external irq edge seen only outside standby
    if (!s_q.in_standby && (s_q.edge_mode ? (!s_q.vi_s2 && s_q.vi_d)
                                          : (s_q.vi_s2 && !s_q.vi_d))) begin
      s_d.irq_req[0] = 1'b1;
    end
    if (s_q.te_s2 && !s_q.te_d) begin
      s_d.test_req = 1'b1;
    end
    if (timer_tick && s_q.st != rsic_pkg::ST_STOP) begin
      s_d.irq_req[1] = 1'b1;
    end
    if (serial_done && (s_q.st != rsic_pkg::ST_STOP || serial_ext_clk)) begin
      s_d.irq_req[2] = 1'b1;
    end

    if (!s_q.rst_s2) begin
      s_d.st = rsic_pkg::ST_RESET;
      if (s_q.st != rsic_pkg::ST_RESET) begin
        s_d.standby_reset = s_q.in_standby;
      end
      s_d.in_standby = 1'b0;
      s_d.irq_req = 3'h0;
      s_d.test_req = 1'b0;
      s_d.irq_en = 3'h0;
      s_d.global_en = 1'b0;
      s_d.in_service = 1'b0;
      s_d.edge_mode = 1'b0;
      s_d.cpu_clk_sel = 4'h0;
      s_d.clk_out_sel = 4'h0;
      s_d.timer_mode = 4'h0;
      s_d.serial_mode = 4'h0;
      s_d.serial_ctrl = 4'h0;
      s_d.port_dir_a = 4'h0;
      s_d.port_dir_b = 4'h0;
      s_d.pullup_sel = 4'h0;
      s_d.out_latch = 4'h0;
      s_d.skip_flags = 3'h0;
    end
  end

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  always_comb begin
    pend = s_q.irq_req & s_q.irq_en & {rsic_pkg::NUM_SRC{s_q.global_en}};
    pick = pend & (~pend + 3'h1);
    // external edge never wakes; halt needs only source enable
    wake = |(s_q.irq_req & s_q.irq_en & rsic_pkg::SRC_WAKE_MASK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    prog_rd = 1'b0;
    prog_addr = rsic_pkg::VEC_RESET_HI;
    if (s_q.st == rsic_pkg::ST_FETCH_HI) begin
      prog_rd = 1'b1;
    end else if (s_q.st == rsic_pkg::ST_FETCH_LO) begin
      prog_rd = 1'b1;
      prog_addr = rsic_pkg::VEC_RESET_LO;
    end else if (s_q.st == rsic_pkg::ST_VEC_PUSH) begin
      prog_rd = 1'b1;
      prog_addr = rsic_pkg::VEC_IRQ_BASE + {8'h00, s_q.vec_idx, 1'b0};
    end else if (s_q.st == rsic_pkg::ST_VEC_LOAD) begin
      prog_rd = 1'b1;
      prog_addr = rsic_pkg::VEC_IRQ_BASE + {8'h00, s_q.vec_idx, 1'b1};
    end
  end

  // two-byte entries so any start address works; low byte read in the load cycle
  assign pc_load_value = {s_q.vec_hi, prog_rdata};
  assign pc_load = (s_q.st == rsic_pkg::ST_FETCH_LO) || (s_q.st == rsic_pkg::ST_VEC_LOAD);
  assign ctx_push = (s_q.st == rsic_pkg::ST_VEC_PUSH);
  assign sys_reset = (s_q.st == rsic_pkg::ST_RESET);
  assign cpu_clk_en = (s_q.st == rsic_pkg::ST_RUN) || (s_q.st == rsic_pkg::ST_VEC_PUSH)
                      || (s_q.st == rsic_pkg::ST_VEC_LOAD);
  assign osc_en = (s_q.st != rsic_pkg::ST_STOP);
  assign timer_run = (s_q.st != rsic_pkg::ST_STOP) && (s_q.st != rsic_pkg::ST_RESET);
  assign clk_out_en = timer_run && (s_q.clk_out_sel != 4'h0);
  // serial in stop only on external clock
  assign serial_run = (s_q.st != rsic_pkg::ST_RESET)
                      && (s_q.st != rsic_pkg::ST_STOP || serial_ext_clk);
  // external vectored input gated in standby
  assign ext_irq_usable = !s_q.in_standby;
  // buffers off until software picks outputs
  assign out_buf_en = !sys_reset && (|s_q.port_dir_a || |s_q.port_dir_b);
  // retention reported, stack and timer count left alone
  assign retain_ok = s_q.standby_reset;
  assign ram_lost_valid = s_q.standby_reset;
  assign ram_lost_lo = rsic_pkg::RAM_LOST_LO;
  assign ram_lost_hi = rsic_pkg::RAM_LOST_HI;

  assign prdata = s_q.rdata;
  // zero-wait reads would miss the registered data, so answer one cycle late
  assign pready = acc && (pwrite || s_q.rdata_seen);
  assign pslverr = acc && !addr_ok;
endmodule : rsic_ctrl
`default_nettype wire

//--- rsic_pkg.sv
// Purpose: shared constants for the reset, standby and interrupt controller
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: offsets, command codes and vector addresses live here
`default_nettype none
package rsic_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] OFS_IRQ_REQ = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MODES = 8'h10;
  localparam logic [7:0] OFS_PORTCFG = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_RETAIN = 8'h1C;
  // program memory vector addresses
  localparam logic [10:0] VEC_RESET_HI = 11'h000;
  localparam logic [10:0] VEC_RESET_LO = 11'h001;
  localparam logic [10:0] VEC_IRQ_BASE = 11'h002;
  // ram window lost when reset ends standby
  localparam logic [5:0] RAM_LOST_LO = 6'h38;
  localparam logic [5:0] RAM_LOST_HI = 6'h3D;
  // irq source index: 0 ext vectored edge, 1 interval timer, 2 serial
  localparam int NUM_SRC = 3;
  localparam logic [2:0] SRC_WAKE_MASK = 3'h6;
  // command register codes
  localparam logic [1:0] CMD_HALT = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam logic [1:0] CMD_RETI = 2'h3;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_RESET, ST_FETCH_HI, ST_FETCH_LO, ST_RUN, ST_HALT, ST_STOP, ST_VEC_PUSH, ST_VEC_LOAD
  } rsic_state_t;
endpackage : rsic_pkg
`default_nettype wire

//--- rsic_ctrl_asserts.sv
// Purpose: port level property checks for rsic_ctrl
// Assumes: one pclk domain, presetn async active low
// Notes: bound into every rsic_ctrl instance
`default_nettype none
module rsic_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic [10:0] prog_addr,
  input wire logic prog_rd,
  input wire logic pc_load,
  input wire logic ctx_push,
  input wire logic sys_reset,
  input wire logic cpu_clk_en,
  input wire logic osc_en,
  input wire logic timer_run,
  input wire logic clk_out_en,
  input wire logic ext_irq_usable,
  input wire logic out_buf_en,
  input wire logic ram_lost_valid,
  input wire logic [5:0] ram_lost_lo,
  input wire logic [5:0] ram_lost_hi,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // reset release, vector fetch, standby clocks, ram window and bus answer
  // ----------------------------------------
  sequence pin_held;
    !reset_pin_n [*4] ##1 reset_pin_n;
  endsequence
  sequence fetch_vec;
    ##[1:16] (prog_rd && prog_addr == 11'h000)
      ##1 (prog_rd && prog_addr == 11'h001 && pc_load);
  endsequence
  a_reset_holds: assert property (!reset_pin_n [*4] |-> sys_reset)
    else $error("system reset not held by reset pin");
  a_sync_release: assert property (pin_held |-> sys_reset)
    else $error("reset released before synchronising");
  a_vector_fetch: assert property (pin_held |-> fetch_vec)
    else $error("reset vector fetch order wrong");
  a_quiet_reset: assert property (sys_reset |-> !pc_load && !ctx_push)
    else $error("load or push during reset");
  a_outputs_off: assert property (sys_reset |-> !out_buf_en)
    else $error("output buffers on during reset");
  a_push_load: assert property (ctx_push |-> ##[1:8] pc_load)
    else $error("context push without vector load");
  a_stop_clocks: assert property (!osc_en |-> !cpu_clk_en && !timer_run && !clk_out_en)
    else $error("clock consumers running in stop");
  a_ext_unusable: assert property (!osc_en |-> !ext_irq_usable)
    else $error("external irq usable in stop");
  a_ram_window: assert property (ram_lost_valid |-> ram_lost_lo == 6'h38 && ram_lost_hi == 6'h3D)
    else $error("lost ram window wrong");
  a_bus_answer: assert property (psel && penable |-> ##[0:16] pready)
    else $error("apb access not answered");
endmodule : rsic_ctrl_asserts
bind rsic_ctrl rsic_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .reset_pin_n(reset_pin_n), .prog_addr(prog_addr), .prog_rd(prog_rd), .pc_load(pc_load),
  .ctx_push(ctx_push), .sys_reset(sys_reset), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
  .timer_run(timer_run), .clk_out_en(clk_out_en), .ext_irq_usable(ext_irq_usable),
  .out_buf_en(out_buf_en), .ram_lost_valid(ram_lost_valid), .ram_lost_lo(ram_lost_lo),
  .ram_lost_hi(ram_lost_hi), .psel(psel), .penable(penable), .pready(pready));
`default_nettype wire

//--- rsic_prog_mem.sv
// Purpose: program memory answering the vector fetch
// Assumes: data needed only while prog_rd is high
// Notes: an idle bus shows the inverse of the last byte, never a stale copy
`default_nettype none
module rsic_prog_mem (
  input wire logic pclk,
  input wire logic [10:0] prog_addr,
  input wire logic prog_rd,
  output logic [7:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:2047];
  logic [7:0] last_q = 8'h5A;
  always_comb prog_rdata = prog_rd ? mem[prog_addr] : ~last_q;
  always_ff @(posedge pclk) if (prog_rd) last_q <= mem[prog_addr];
endmodule : rsic_prog_mem
`default_nettype wire

//--- rsic_ctrl_tb.sv
// Purpose: self-checking bench for rsic_ctrl
// Assumes: control fields sit at the low bits of each word
// Notes: vector entries take two bytes per source from 002
`default_nettype none
module rsic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, reset_pin_n, ext_vectored_irq_in, ext_test_edge_in, timer_tick;
  logic serial_done, prog_rd, pc_load, ctx_push, sys_reset, cpu_clk_en, osc_en, timer_run;
  logic clk_out_en, serial_run, ext_irq_usable, out_buf_en, retain_ok, ram_lost_valid;
  logic psel, penable, pwrite, pready, pslverr, err, hit;
  logic [10:0] prog_addr, pc_load_value;
  logic [7:0] prog_rdata, paddr;
  logic [5:0] ram_lost_lo, ram_lost_hi;
  logic [10:0] ld_val;
  logic [7:0] ofs5[0:4];
  logic [31:0] pwdata, prdata, rd;
  int mismatches, checks_done, seed, rom_m[0:9];
  rsic_ctrl uut (.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
    .ext_vectored_irq_in(ext_vectored_irq_in), .ext_test_edge_in(ext_test_edge_in),
    .timer_tick(timer_tick), .serial_done(serial_done), .prog_rdata(prog_rdata),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .pc_load_value(pc_load_value),
    .pc_load(pc_load), .ctx_push(ctx_push), .sys_reset(sys_reset), .cpu_clk_en(cpu_clk_en),
    .osc_en(osc_en), .timer_run(timer_run), .clk_out_en(clk_out_en), .serial_run(serial_run),
    .ext_irq_usable(ext_irq_usable), .out_buf_en(out_buf_en), .retain_ok(retain_ok),
    .ram_lost_valid(ram_lost_valid), .ram_lost_lo(ram_lost_lo), .ram_lost_hi(ram_lost_hi),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rsic_prog_mem mem_i (.pclk(pclk), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_rdata(prog_rdata));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ok;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 50) begin
      // mid-cycle sample: what stands here is what the next rising edge sees
      @(negedge pclk);
      n++;
      ok = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      mismatches++;
      final_report();
    end
  endtask : apb
  task automatic wait_load();
    hit = 1'b0;
    for (int i = 0; i < 64 && !hit; i++) begin
      @(negedge pclk);
      hit = (pc_load === 1'b1);
      ld_val = pc_load_value;
    end
    @(posedge pclk);
  endtask : wait_load
  // outside source holds reset low, then releases
  task automatic pin_reset();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge pclk);
    reset_pin_n <= 1'b1;
    wait_load();
  endtask : pin_reset
  function automatic logic [10:0] vec(input int b);
    return {rom_m[b][2:0], rom_m[b+1][7:0]};
  endfunction : vec
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(5000 * 50);
    mismatches++;
    final_report();
  end
  initial begin
    {presetn, reset_pin_n, ext_vectored_irq_in, ext_test_edge_in, timer_tick} = 5'h0;
    {serial_done, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    seed = 18;
    for (int a = 0; a < 2048; a++) mem_i.mem[a] = a[7:0] ^ 8'hA5;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      for (int a = 0; a < 10; a++) begin
        rom_m[a] = $random(seed) & 255;
        mem_i.mem[a] = rom_m[a][7:0];
      end
      pin_reset();
      chk("reset pc", ld_val, vec(0));
    end
    chk("out_buf_en", out_buf_en, 0);
    ofs5 = '{rsic_pkg::OFS_CTRL, rsic_pkg::OFS_IRQ_EN, rsic_pkg::OFS_IRQ_REQ,
             rsic_pkg::OFS_MODES, rsic_pkg::OFS_PORTCFG};
    // write ones to the five control words, then a pin reset must clear them all
    for (int k = 0; k < 5; k++) apb(1'b1, ofs5[k], 32'hFFFF_FFFF);
    apb(1'b0, rsic_pkg::OFS_CTRL, 0);
    chk("ctrl word", rd, 32'h0000_0073);
    chk("out_buf_en driven", out_buf_en, 1);
    pin_reset();
    chk("out_buf_en", out_buf_en, 0);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, ofs5[k], 0);
      chk("reset word", rd, rsic_pkg::ZERO32);
    end
    apb(1'b0, 8'hF0, 0);
    chk("unmapped error", err, 1);
    $display("test reset done");
    apb(1'b1, rsic_pkg::OFS_IRQ_EN, 32'h6);
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    wait_load();
    chk("vector with master off", hit, 0);
    ext_test_edge_in <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_test_edge_in <= 1'b0;
    wait_load();
    chk("vector from test edge", hit, 0);
    apb(1'b0, rsic_pkg::OFS_IRQ_REQ, 0);
    chk("timer flag", rd[1], 1);
    chk("test flag", rd[3], 1);
    apb(1'b1, rsic_pkg::OFS_CTRL, 32'h1);
    wait_load();
    chk("timer vector", ld_val, vec(4));
    serial_done <= 1'b1;
    @(posedge pclk);
    serial_done <= 1'b0;
    wait_load();
    chk("nested vector", hit, 0);
    $display("test irq done");
    pin_reset();
    apb(1'b1, rsic_pkg::OFS_IRQ_EN, 32'h3);
    apb(1'b1, rsic_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, rsic_pkg::OFS_CMD, {30'h0, rsic_pkg::CMD_HALT});
    repeat (4) @(posedge pclk);
    chk("halt clocks", {cpu_clk_en, osc_en, timer_run}, 3'h3);
    chk("ext irq in halt", ext_irq_usable, 0);
    ext_vectored_irq_in <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_vectored_irq_in <= 1'b0;
    wait_load();
    chk("wake by ext pin", hit, 0);
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    wait_load();
    chk("halt wake vector", ld_val, vec(4));
    $display("test halt done");
    apb(1'b1, rsic_pkg::OFS_MODES, 32'h0000_8000);
    apb(1'b1, rsic_pkg::OFS_CMD, {30'h0, rsic_pkg::CMD_STOP});
    repeat (4) @(posedge pclk);
    chk("stop clocks", {osc_en, cpu_clk_en, timer_run, clk_out_en}, 4'h0);
    chk("serial in stop", serial_run, 1);
    pin_reset();
    chk("stop reset pc", ld_val, vec(0));
    chk("retain", retain_ok, 1);
    chk("ram window", {ram_lost_valid, ram_lost_lo, ram_lost_hi}, {1'b1, 6'h38, 6'h3D});
    $display("test stop done");
    final_report();
  end
endmodule : rsic_ctrl_tb
`default_nettype wire
